// >>> pkg/actl_pkg.sv
// package of constants for the converter trigger and conversion-end interrupt block
// Notes on behaviour
// - external trigger only when select equals 11
// - trigger falling edge sets start bit
// - triggered conversion behaves like software start
// - conversion end sets the end flag
// - request only when flag and enable set
// - end request activates transfer and dma controllers
package actl_pkg;
    // register byte offsets
    localparam logic [11:0] ADDR_CTRL     = 12'h000;  // converter_control_reg
    localparam logic [11:0] ADDR_CSR      = 12'h004;  // converter_ctrl_status_reg
    localparam logic [11:0] ADDR_IRQ_STAT = 12'h008;  // sticky event status
    localparam logic [11:0] ADDR_IRQ_MASK = 12'h00C;  // event mask
    // converter_control_reg fields
    localparam int TRIG_SEL_LO_POS = 0;  // trigger_select_lo
    localparam int TRIG_SEL_HI_POS = 1;  // trigger_select_hi
    localparam int SCAN_MODE_POS   = 2;  // scan mode select
    localparam logic [1:0] TRIG_SEL_EXT = 2'b11;  // external trigger code
    // converter_ctrl_status_reg fields
    localparam int END_FLAG_POS  = 7;  // conversion_end_flag
    localparam int IRQ_EN_POS    = 6;  // conversion_end_irq_enable
    localparam int START_POS     = 5;  // conversion_start_bit
    localparam int CHAN_LSB      = 0;  // last channel number
    localparam int CHAN_W        = 3;  // channel field width
    // sticky status bits
    localparam int EV_END_POS  = 0;  // a conversion finished
    localparam int EV_TRIG_POS = 1;  // an external trigger arrived
    localparam int EV_W        = 2;  // event count
    // reset values
    localparam logic [2:0]      CTRL_RST = 3'h0;
    localparam logic [EV_W-1:0] MASK_RST = 2'h0;
    // conversion time per channel, in system clocks
    localparam logic [5:0] CONV_CYCLES = 6'h22;
endpackage : actl_pkg

// >>> src/actl_top.sv
// converter trigger control, conversion sequencing and conversion-end interrupt
//
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/1ns
module actl_top
    import actl_pkg::*;
(
    input  wire logic        i_sys_clk,        // 10 MHz system clock
    input  wire logic        i_rst_b,          // synchronous reset, active low
    input  wire logic        i_psel,           // apb select
    input  wire logic        i_penable,        // apb access phase
    input  wire logic        i_pwrite,         // apb direction
    input  wire logic [11:0] i_paddr,          // apb byte address
    input  wire logic [31:0] i_pwdata,         // apb write data
    input  wire logic        i_ext_conv_trigger_pin, // external trigger pin
    output logic      [31:0] o_prdata,         // apb read data
    output logic             o_pready,         // apb ready
    output logic             o_pslverr,        // apb error on unmapped address
    output logic             o_conversion_end_irq, // request to the interrupt controller
    output logic             o_transfer_controller_req, // activation of transfer controller
    output logic             o_dma_controller_req, // activation of dma controller
    output logic             o_irq,            // masked event interrupt
    output logic             o_conv_busy       // a conversion is running
);
    typedef enum logic [1:0] {ACTL_IDLE, ACTL_CONV} actl_state_e;

    logic [2:0]      ctrl;          // converter_control_reg contents
    logic            start_bit;     // conversion_start_bit
    logic            end_flag;      // conversion_end_flag
    logic            irq_en;        // conversion_end_irq_enable
    logic [CHAN_W-1:0] chan_last;   // highest channel to convert
    logic [CHAN_W-1:0] chan_cur;    // channel being converted
    logic [5:0]      conv_cnt;      // cycles left for this channel
    actl_state_e     state;         // sequencer state
    logic [EV_W-1:0] ev_stat;       // sticky events
    logic [EV_W-1:0] ev_mask;       // event mask
    logic            trig_meta;     // synchroniser first stage
    logic            trig_sync;     // synchroniser second stage
    logic            trig_prev;     // previous synchronised sample
    logic            ext_fall;      // qualified falling edge
    logic            conv_done;     // last channel completed this cycle
    logic            wr_acc;        // apb write access phase
    logic            rd_acc;        // apb read access phase
    logic            end_flag_clr;  // software writes 0 to the end flag

    // address map check, used for the error response only
    function automatic logic is_mapped(input logic [11:0] a);
        return (a == ADDR_CTRL) || (a == ADDR_CSR) || (a == ADDR_IRQ_STAT) || (a == ADDR_IRQ_MASK);
    endfunction : is_mapped

    assign wr_acc = i_psel & i_penable & i_pwrite;
    assign rd_acc = i_psel & i_penable & ~i_pwrite;
    assign end_flag_clr = wr_acc & (i_paddr == ADDR_CSR) & ~i_pwdata[END_FLAG_POS];

    // two-stage synchroniser and edge history
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            trig_meta <= 1'b1;
            trig_sync <= 1'b1;
            trig_prev <= 1'b1;
        end else begin
            trig_meta <= i_ext_conv_trigger_pin;
            trig_sync <= trig_meta;
            trig_prev <= trig_sync;
        end
    end

    // falling edge honoured only with select 11
    assign ext_fall = trig_prev & ~trig_sync
                      & (ctrl[TRIG_SEL_HI_POS:TRIG_SEL_LO_POS] == TRIG_SEL_EXT);

    // apb ready is a zero-wait-state answer, error on unmapped address
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
        end else begin
            o_pready  <= i_psel & ~i_penable;
            o_pslverr <= i_psel & ~i_penable & ~is_mapped(i_paddr);
        end
    end

    // read data registered at setup so it stands with pready
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            o_prdata <= 32'h0000_0000;
        end else if (i_psel & ~i_penable & ~i_pwrite) begin
            unique case (i_paddr)
                ADDR_CTRL:     o_prdata <= {29'h0, ctrl};
                ADDR_CSR:      o_prdata <= {24'h0, end_flag, irq_en, start_bit, 2'b00, chan_last};
                ADDR_IRQ_STAT: o_prdata <= {30'h0, ev_stat};
                ADDR_IRQ_MASK: o_prdata <= {30'h0, ev_mask};
                default:       o_prdata <= 32'h0000_0000;
            endcase
        end
    end

    // control register write
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            ctrl <= CTRL_RST;
        end else if (wr_acc && o_pready && i_paddr == ADDR_CTRL) begin
            ctrl <= i_pwdata[2:0];
        end
    end

    // enable and channel fields of the status register
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            irq_en    <= 1'b0;
            chan_last <= '0;
        end else if (wr_acc && o_pready && i_paddr == ADDR_CSR) begin
            irq_en    <= i_pwdata[IRQ_EN_POS];
            chan_last <= i_pwdata[CHAN_LSB +: CHAN_W];
        end
    end

    // start bit: set by software or trigger, clears when sequence ends
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            start_bit <= 1'b0;
        end else if (ext_fall) begin
            start_bit <= 1'b1;
        end else if (wr_acc && o_pready && i_paddr == ADDR_CSR) begin
            start_bit <= i_pwdata[START_POS];
        end else if (conv_done) begin
            start_bit <= 1'b0;
        end
    end

    // sequencer; same path for both start sources
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            state    <= ACTL_IDLE;
            chan_cur <= '0;
            conv_cnt <= '0;
        end else begin
            unique case (state)
                ACTL_IDLE: begin
                    if (start_bit) begin
                        state    <= ACTL_CONV;
                        chan_cur <= ctrl[SCAN_MODE_POS] ? '0 : chan_last;
                        conv_cnt <= CONV_CYCLES;
                    end
                end
                ACTL_CONV: begin
                    if (!start_bit) begin
                        state <= ACTL_IDLE; // software abort
                    end else if (conv_cnt != 6'h01) begin
                        conv_cnt <= conv_cnt - 6'h01;
                    end else if (chan_cur == chan_last) begin
                        state <= ACTL_IDLE; // single or last scan channel
                    end else begin
                        chan_cur <= chan_cur + 1'b1;
                        conv_cnt <= CONV_CYCLES;
                    end
                end
            endcase
        end
    end

    assign conv_done = (state == ACTL_CONV) & start_bit & (conv_cnt == 6'h01) & (chan_cur == chan_last);

    // end flag: set wins over clear by writing 0
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            end_flag <= 1'b0;
        end else if (conv_done) begin
            end_flag <= 1'b1;
        end else if (end_flag_clr && o_pready) begin
            end_flag <= 1'b0;
        end
    end

    // sticky events, write one to clear, set wins
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            ev_stat <= '0;
        end else begin
            for (int i = 0; i < EV_W; i++) begin
                if ((i == EV_END_POS && conv_done) || (i == EV_TRIG_POS && ext_fall)) begin
                    ev_stat[i] <= 1'b1;
                end else if (wr_acc && o_pready && i_paddr == ADDR_IRQ_STAT && i_pwdata[i]) begin
                    ev_stat[i] <= 1'b0;
                end
            end
        end
    end

    // mask register
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            ev_mask <= MASK_RST;
        end else if (wr_acc && o_pready && i_paddr == ADDR_IRQ_MASK) begin
            ev_mask <= i_pwdata[EV_W-1:0];
        end
    end

    // registered request outputs
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            o_conversion_end_irq      <= 1'b0;
            o_transfer_controller_req <= 1'b0;
            o_dma_controller_req      <= 1'b0;
            o_irq                     <= 1'b0;
            o_conv_busy               <= 1'b0;
        end else begin
            o_conversion_end_irq      <= end_flag & irq_en;
            o_transfer_controller_req <= end_flag & irq_en;
            o_dma_controller_req      <= end_flag & irq_en;
            o_irq                     <= |(ev_stat & ev_mask);
            o_conv_busy               <= (state == ACTL_CONV);
        end
    end
endmodule : actl_top

// >>> verification/actl_partner.sv
// trigger source standing at the far side of the converter block
`timescale 1ns/1ns
module actl_partner (
    input  wire logic i_sys_clk, // system clock
    output logic      o_pin      // external trigger pin, idles high
);
    // pin idles high until a pulse is asked for
    initial o_pin = 1'h1;
    // one low pulse of four clocks, changed just after rising edges
    task fire;
        @(posedge i_sys_clk);
        o_pin <= 1'h0;
        repeat (4) @(posedge i_sys_clk);
        o_pin <= 1'h1;
    endtask : fire
endmodule : actl_partner

// >>> verification/actl_top_checker.sv
// assertions on the ports of the converter trigger block
`timescale 1ns/1ns
module actl_top_checker
    import actl_pkg::*;
(
    input wire logic        i_sys_clk,
    input wire logic        i_rst_b,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic        o_pready,
    input wire logic        o_pslverr,
    input wire logic        o_conversion_end_irq,
    input wire logic        o_transfer_controller_req,
    input wire logic        o_dma_controller_req,
    input wire logic        o_irq,
    input wire logic        o_conv_busy
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_b);
    // setup cycle of an access
    sequence apb_setup;
        i_psel && !i_penable;
    endsequence
    // completed write to the control and status word
    sequence csr_write;
        i_psel && i_penable && o_pready && i_pwrite && (i_paddr == ADDR_CSR);
    endsequence
    a_ready_after_setup: assert property (apb_setup |=> o_pready)
        else $error("ready missing after setup");
    a_ready_needs_setup: assert property (o_pready |-> $past(i_psel && !i_penable))
        else $error("ready without setup");
    a_error_with_ready: assert property (o_pslverr |-> o_pready)
        else $error("error outside ready");
    a_enable_off_quiet: assert property ((csr_write ##0 !i_pwdata[IRQ_EN_POS]) |-> ##2 !o_conversion_end_irq)
        else $error("end request with enable cleared");
    a_transfer_req_tracks: assert property (o_transfer_controller_req == o_conversion_end_irq)
        else $error("transfer request differs");
    a_dma_req_tracks: assert property (o_dma_controller_req == o_conversion_end_irq)
        else $error("dma request differs");
    a_reset_quiet: assert property (disable iff (1'h0) !i_rst_b |=> !o_irq && !o_conv_busy && !o_conversion_end_irq)
        else $error("outputs active after reset");
    c_conversion: cover property ($fell(o_conv_busy));
endmodule : actl_top_checker

bind actl_top actl_top_checker u_chk (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .o_conversion_end_irq(o_conversion_end_irq),
    .o_transfer_controller_req(o_transfer_controller_req), .o_dma_controller_req(o_dma_controller_req),
    .o_irq(o_irq), .o_conv_busy(o_conv_busy));

// >>> verification/adc_trigger_and_end_interrupt_test.sv
// testbench for the converter trigger and conversion-end interrupt block
`timescale 1ns/1ns
module adc_trigger_and_end_interrupt_test
    import actl_pkg::*;
;
    logic        i_sys_clk, i_rst_b, psel, pen, pwr, pin, pready, perr, err;
    logic        ce_irq, tc_req, dma_req, irq, busy;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    int          miscompares, n_tests, cyc;
    actl_partner P (.i_sys_clk(i_sys_clk), .o_pin(pin));
    actl_top DUT (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .i_ext_conv_trigger_pin(pin),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(perr), .o_conversion_end_irq(ce_irq),
        .o_transfer_controller_req(tc_req), .o_dma_controller_req(dma_req), .o_irq(irq),
        .o_conv_busy(busy));
    // free running clock, 100 ns period
    initial begin
        i_sys_clk = 1'h0;
        forever #50 i_sys_clk = ~i_sys_clk;
    end
    // compare and count
    // 33 bits so that a flag can ride above a full data word
    task chk(input logic [32:0] seen, input logic [32:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask : chk
    // one apb access, held until ready is sampled high
    task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge i_sys_clk);
        psel   <= 1'h1;
        pwr    <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge i_sys_clk);
        pen <= 1'h1;
        // wait for ready; only the watchdog ends a hang
        do begin
            @(posedge i_sys_clk);
        end while (pready !== 1'h1);
        rd  = prdata;
        err = perr;
        psel <= 1'h0;
        pen  <= 1'h0;
    endtask : apb
    // length of the next busy period, zero if none starts
    task run;
        int n;
        n   = 0;
        cyc = 0;
        while (busy !== 1'h1 && n < 30) begin
            @(posedge i_sys_clk);
            n++;
        end
        while (busy === 1'h1 && cyc < 500) begin
            @(posedge i_sys_clk);
            cyc++;
        end
    endtask : run
    // verdict and end of run
    task finish_test;
        $display("tests %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : finish_test
    // watchdog against a hang
    initial begin
        repeat (20000) @(posedge i_sys_clk);
        miscompares++;
        finish_test;
    end
    // main sequence
    initial begin
        {i_rst_b, psel, pen, pwr, paddr, pwdata} = '0;
        miscompares = 0;
        n_tests = 0;
        repeat (12) @(posedge i_sys_clk);
        i_rst_b <= 1'h1;
        apb(ADDR_CTRL, 1'h0, 32'h0000_0000);
        chk(rd, 32'(CTRL_RST));
        apb(ADDR_IRQ_MASK, 1'h0, 32'h0000_0000);
        chk(rd, 32'(MASK_RST));
        apb(12'h010, 1'h0, 32'h0000_0000);
        chk({err, rd}, 33'h1_0000_0000);
        // software start, one channel, request enabled
        apb(ADDR_CSR, 1'h1, 32'h0000_0060);
        run;
        chk(cyc, int'(CONV_CYCLES));
        apb(ADDR_CSR, 1'h0, 32'h0000_0000);
        chk(rd, 32'h0000_00C0);
        chk({ce_irq, tc_req, dma_req}, 3'h7);
        apb(ADDR_CSR, 1'h1, 32'h0000_0080);
        apb(ADDR_CSR, 1'h0, 32'h0000_0000);
        chk({rd, ce_irq}, 33'h0_0000_0100);
        // sticky status, mask and interrupt line
        chk(irq, 1'h0);
        apb(ADDR_IRQ_MASK, 1'h1, 32'h0000_0003);
        // mask lands at the ready edge, the line follows one edge later
        repeat (2) @(posedge i_sys_clk);
        chk(irq, 1'h1);
        apb(ADDR_IRQ_STAT, 1'h1, 32'h0000_0001);
        apb(ADDR_IRQ_STAT, 1'h0, 32'h0000_0000);
        chk({rd, irq}, 33'h0);
        apb(ADDR_CSR, 1'h1, 32'h0000_0000);
        // pin acts only with select 11
        for (int s = 0; s < 4; s++) begin
            apb(ADDR_CTRL, 1'h1, 32'(s));
            P.fire();
            run;
            chk(cyc, (s == 3) ? int'(CONV_CYCLES) : 0);
            apb(ADDR_CSR, 1'h0, 32'h0000_0000);
            chk(rd, (s == 3) ? 32'h0000_0080 : 32'h0000_0000);
            apb(ADDR_CSR, 1'h1, 32'h0000_0000);
        end
        // triggered scan over channels 0..2
        apb(ADDR_CTRL, 1'h1, 32'h0000_0007);
        apb(ADDR_CSR, 1'h1, 32'h0000_0042);
        P.fire();
        run;
        chk(cyc, 3 * int'(CONV_CYCLES));
        chk({ce_irq, tc_req, dma_req}, 3'h7);
        apb(ADDR_IRQ_STAT, 1'h0, 32'h0000_0000);
        chk({rd, irq}, 33'h0_0000_0007);
        finish_test;
    end
endmodule : adc_trigger_and_end_interrupt_test
